// ==== verif/ssr_cell_set_reset_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssr_cell_set_reset_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [15:0] stim = 16'hc1cb; // Ce cfg pin inv src node init en lsr d cke
    logic [1:0] dataOut;
    logic running;
    int nErrors = 0;
    int numChecks = 0;
    int cycles = 0;
    ssr_cell_set_reset #(.NUM_FF(2)) dut (.clk, .rst_n, .ce(stim[15]),
        .configDone(stim[14]), .gsrPin(stim[13]), .gsrInvert(stim[12]),
        .gsrSource(stim[11]), .gsrNode(stim[10]), .initSet(stim[9:8]),
        .localEnable(stim[7:6]), .localSetReset(stim[5:4]),
        .dataIn(stim[3:2]), .clkEn(stim[1:0]), .dataOut, .running);
    always #5 clk = ~clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apply(input logic [15:0] s, input int n,
        input logic [2:0] exp);
        stim = s;
        repeat (n) @(negedge clk);
        check({running, dataOut}, exp);
    endtask : apply
    task automatic tally_and_finish();
        if (nErrors == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        if (++cycles == 300) begin
            nErrors++;
            tally_and_finish();
        end
    end
    initial begin
        apply(16'hc1cb, 5, 3'h1);
        rst_n = 1'h1;
        apply(16'hc1cb, 3, 3'h6);
        apply(16'hc1fb, 1, 3'h5);
        apply(16'hc17b, 1, 3'h7);
        apply(16'hc14b, 1, 3'h6);
        apply(16'he14b, 5, 3'h1);
        apply(16'hc14b, 5, 3'h6);
        apply(16'hd14b, 5, 3'h1);
        apply(16'hd94b, 3, 3'h6);
        apply(16'hdd4b, 1, 3'h5);
        apply(16'h994b, 2, 3'h1);
        apply(16'h9a4b, 1, 3'h2);
        apply(16'hda47, 3, 3'h5);
        apply(16'hda77, 1, 3'h4);
        apply(16'hda4e, 1, 3'h6);
        apply(16'h5a47, 3, 3'h6);
        tally_and_finish();
    end
endmodule : ssr_cell_set_reset_tb
`default_nettype wire

// ==== verif/ssr_check_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssr_check_monitor #(parameter int NUM_FF = 2) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic ce, // Enable
    input wire logic configDone, // Configured
    input wire logic [NUM_FF-1:0] initSet, // Choice
    input wire logic [NUM_FF-1:0] localEnable, // Local on
    input wire logic [NUM_FF-1:0] localSetReset, // Local force
    input wire logic gsrSource, // Source
    input wire logic gsrNode, // Node
    input wire logic [NUM_FF-1:0] dataOut, // Flops
    input wire logic running // Released
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    local_force_a: assert property (
        ((dataOut ^ initSet) & localSetReset & localEnable) == '0)
        else $error("local force lost");
    config_hold_a: assert property (
        ce && !configDone |=> dataOut == initSet) else $error("config hold");
    run_drop_a: assert property (
        ce && !configDone ##1 ce |=> !running) else $error("running stuck");
    node_force_a: assert property (
        ce && gsrSource && gsrNode |=> dataOut == initSet) else $error("node");
    node_run_a: assert property (
        (ce && configDone && gsrSource && !gsrNode) [*3] |=> running)
        else $error("node release");
    node_drop_a: assert property (
        ce && gsrSource && gsrNode ##1 ce |=> !running)
        else $error("node run");
    ce_hold_a: assert property (
        !ce && running && localSetReset == '0 ##1 localSetReset == '0
        |-> $stable(dataOut)) else $error("ce hold");
    force_first_a: assert property (
        $fell(running) |-> $past(dataOut) == $past(initSet))
        else $error("fell");
    cover property (localSetReset != '0);
    cover property (gsrSource && gsrNode);
    cover property (!configDone);
endmodule : ssr_check_monitor
bind ssr_cell_set_reset ssr_check_monitor #(.NUM_FF(NUM_FF)) mon (.clk,
    .rst_n, .ce, .configDone, .initSet, .localEnable, .localSetReset,
    .gsrSource, .gsrNode, .dataOut, .running);
`default_nettype wire

// ==== verilog/ssr_cell_set_reset.sv ====
// Function
// - Local set/reset forces the configured state
// - After configuration start in configured state
// - One bit governs init, global, local
// - Choice held separately per flip-flop
// - Local set/reset disableable per flip-flop
// - Local input active high, never inverted
// - Global forces configured state, net sampled only while ce is high
// - Global net on dedicated distribution
// - Set elements set by both sources
// - Global net drivable from input pin
// - Optional inversion after input buffer
// - Internal node may source global net
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module ssr_cell_set_reset #(
    parameter int NUM_FF = `SSR_FF_PER_CELL * `SSR_NUM_CELLS
) (
    input wire logic clk,                     // Cell clock
    input wire logic rst_n,                   // Power-up reset, active low
    input wire logic ce,                      // Clock enable, freezes state except local set/reset
    input wire logic configDone,              // Configuration complete
    input wire logic [NUM_FF-1:0] initSet,    // Per-flop set choice
    input wire logic [NUM_FF-1:0] localEnable,// Per-flop local enable
    input wire logic [NUM_FF-1:0] localSetReset, // Local set/reset lines
    input wire logic [NUM_FF-1:0] dataIn,     // Flop data
    input wire logic [NUM_FF-1:0] clkEn,      // Per-flop clock enable
    input wire logic gsrPin,                  // Global reset pin
    input wire logic gsrInvert,               // Invert pin sense
    input wire logic gsrSource,               // 0 = pin, 1 = node
    input wire logic gsrNode,                 // Internal node source
    output logic [NUM_FF-1:0] dataOut,        // Flop outputs
    output logic running                      // Configured and released
);

    logic pinSync1;
    logic pinSync2;
    ssr_pkg::ssr_phase_t phase_reg;
    logic gsrActive_reg;
    logic gsrActive_next;
    logic [NUM_FF-1:0] q;

    // ****************************************************************
    // Pin input synchroniser
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
        end else if (ce) begin
            pinSync1 <= gsrPin;
            pinSync2 <= pinSync1;
        end
    end

    // ****************************************************************
    // Global source select and configuration phase
    // ****************************************************************
    always_comb begin
        if (gsrSource == `SSR_GSRC_NODE) begin
            gsrActive_next = gsrNode;
        end else begin
            gsrActive_next = pinSync2 ^ gsrInvert;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= ssr_pkg::SSR_PHASE_CONFIG;
        end else if (ce) begin
            case (phase_reg)
                ssr_pkg::SSR_PHASE_CONFIG: begin
                    if (configDone) begin
                        phase_reg <= ssr_pkg::SSR_PHASE_RUN;
                    end
                end
                ssr_pkg::SSR_PHASE_RUN: begin
                    if (!configDone) begin
                        phase_reg <= ssr_pkg::SSR_PHASE_CONFIG;
                    end
                end
                default: phase_reg <= ssr_pkg::SSR_PHASE_CONFIG;
            endcase
        end
    end

    // Registered global force: held through power-up and configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gsrActive_reg <= 1'b1;
        end else if (ce) begin
            gsrActive_reg <= gsrActive_next
                | (phase_reg != ssr_pkg::SSR_PHASE_RUN)
                | !configDone;
        end
    end

    // ****************************************************************
    // Storage elements on a dedicated global net
    // ****************************************************************
    for (genvar i = 0; i < NUM_FF; i++) begin : gFf
        ssr_storage_ff uFf (
            .clk(clk),
            .ce(ce),
            .clkEn(clkEn[i]),
            .d(dataIn[i]),
            .initSet(initSet[i]),
            .localEnable(localEnable[i]),
            .localSetReset(localSetReset[i]),
            .globalForce(gsrActive_reg),
            .q(q[i])
        );
    end

    assign dataOut = q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
        end else if (ce) begin
            running <= !gsrActive_reg;
        end
    end

endmodule : ssr_cell_set_reset

`default_nettype wire

// ==== verilog/ssr_map.svh ====
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// ****************************************************************
// Source selection for the global set/reset net
// ****************************************************************
`define SSR_GSRC_PIN 1'b0
`define SSR_GSRC_NODE 1'b1

// ****************************************************************
// Configured state encodings
// ****************************************************************
`define SSR_INIT_RESET 1'b0
`define SSR_INIT_SET 1'b1

// ****************************************************************
// Default cell geometry
// ****************************************************************
`define SSR_FF_PER_CELL 2
`define SSR_NUM_CELLS 1

`endif

// ==== verilog/ssr_pkg.sv ====
`default_nettype none
package ssr_pkg;
    typedef enum logic [1:0] {
        SSR_PHASE_CONFIG = 2'b01,
        SSR_PHASE_RUN = 2'b10
    } ssr_phase_t;
endpackage : ssr_pkg
`default_nettype wire

// ==== verilog/ssr_storage_ff.sv ====
`timescale 1ns/10ps
`default_nettype none

module ssr_storage_ff (
    input wire logic clk,           // Cell clock
    input wire logic ce,            // Global clock enable
    input wire logic clkEn,         // Per-element clock enable
    input wire logic d,             // Data in
    input wire logic initSet,       // Configured state, 1 = set
    input wire logic localEnable,   // Local set/reset enable
    input wire logic localSetReset, // Local set/reset, active high
    input wire logic globalForce,   // Global set/reset, active high
    output logic q                  // Stored value
);

    logic forceNow;
    logic setNow;
    logic clrNow;

    // Local input only counts when enabled; no inversion here
    assign forceNow = globalForce
        | (localEnable & localSetReset);
    // Split into set and clear so the held state tracks the configured bit
    assign setNow = forceNow & initSet;
    assign clrNow = forceNow & ~initSet;

    // ****************************************************************
    // Storage element with asynchronous set/reset to configured state
    // ****************************************************************
    always_ff @(posedge clk or posedge setNow or posedge clrNow) begin
        if (clrNow) begin
            q <= 1'b0;
        end else if (setNow) begin
            q <= 1'b1;
        end else if (ce && clkEn) begin
            q <= d;
        end
    end

endmodule : ssr_storage_ff

`default_nettype wire
